// ### design/dcr_pkg.sv
/*
 * Constants, field layouts and enumerations for the DMA channel address,
 * offset, count and block-size register block.
 * Assumes a four-channel controller reached over APB with 32-bit data.
 */
package dcr_pkg;
    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int NUM_CHAN = 4;
    localparam int CHAN_W = 2;
    localparam int ADDR_W = 8;
    localparam int FIFO_DEPTH = 32;

    // ****************************************************************
    // Register offsets inside one channel window
    // ****************************************************************
    localparam logic [4:0] OFS_SOURCE_ADDRESS = 5'h00;
    localparam logic [4:0] OFS_DESTINATION_ADDRESS = 5'h04;
    localparam logic [4:0] OFS_ADDRESS_OFFSET = 5'h08;
    localparam logic [4:0] OFS_TRANSFER_COUNT = 5'h0C;
    localparam logic [4:0] OFS_BLOCK_SIZE = 5'h10;
    localparam logic [4:0] OFS_ADDRESS_CONTROL = 5'h14;
    localparam logic [4:0] OFS_CHANNEL_STATUS = 5'h18;
    localparam logic [4:0] OFS_BLOCK_BYTES = 5'h1C;
    localparam int WIN_LSB = 0;
    localparam int WIN_MSB = 4;
    localparam int CHAN_LSB = 5;
    localparam int CHAN_MSB = 6;
    localparam int MAP_BIT = 7;

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    localparam int CTL_EN = 0;
    localparam int CTL_SIZE_LSB = 1;
    localparam int CTL_MODE_LSB = 3;
    localparam int CTL_SINGLE = 5;
    localparam int CTL_DIR = 6;
    localparam int CTL_SUPD_LSB = 7;
    localparam int CTL_DUPD_LSB = 9;
    localparam logic [31:0] CTL_MASK = 32'h000007FF;
    localparam int STS_ACTIVE = 0;
    localparam int STS_COUNT_END = 1;
    localparam int STS_BLOCK_END = 2;
    localparam int STS_FREE_RUN = 3;
    localparam int BLK_RELOAD_LSB = 16;
    localparam int BLK_REMAIN_LSB = 0;
    localparam int BLK_FIELD_W = 16;

    // ****************************************************************
    // Values
    // ****************************************************************
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [31:0] COUNT_FREE_RUN = 32'h00000000;
    localparam logic [15:0] BLK_ZERO = 16'h0000;
    localparam logic [15:0] BLK_STEP = 16'h0001;
    localparam logic [16:0] BLK_MAX_UNITS = 17'h10000;
    localparam logic [31:0] BYTES_BYTE = 32'h00000001;
    localparam logic [31:0] BYTES_WORD = 32'h00000002;
    localparam logic [31:0] BYTES_LONG = 32'h00000004;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } dcr_size_t;

    typedef enum logic [1:0] {
        MD_NORMAL = 2'h0,
        MD_REPEAT = 2'h1,
        MD_BLOCK = 2'h2
    } dcr_mode_t;

    typedef enum logic [1:0] {
        UPD_FIXED = 2'h0,
        UPD_OFFSET = 2'h1,
        UPD_INC = 2'h2,
        UPD_DEC = 2'h3
    } dcr_upd_t;
endpackage

// ### design/dcr_regs.sv
/*
 * Channel address, offset, total-count and block-size registers of a
 * four-channel DMA controller, an APB slave for them, and a FIFO that
 * buffers transfer events from the engine before the registers advance.
 * Assumes the transfer engine reports one event per completed data
 * transfer, on the same clock, and that software obeys the access limits.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Destination address readable, writable, advances per transfer
// - Single mode, direction 0 ignores destination
// - Single mode, direction 1 ignores source
// - One readable writable offset per channel
// - Total count counts bytes
// - Zero count runs free, counter frozen
// - All-ones count means maximum byte size
// - Count drops by 1, 2 or 4
// - Block size acts only in repeat/block
// - Upper field is reload size in units
// - Zero reload means 65536 units
// - Upper field stays fixed while operating
// - Lower field counts down remaining units
// - Lower field reloads from upper at zero
// - Block bytes span unit count times size
// ********************************************************************
// Event FIFO
// ********************************************************************
module dcr_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] fill;
    logic push;
    logic pop;
    assign in_ready = (fill != FULL_COUNT);
    assign out_valid = (fill != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// ********************************************************************
// Register block
// ********************************************************************
module dcr_regs #(
    parameter int NUM_CHAN = dcr_pkg::NUM_CHAN,
    parameter int FIFO_DEPTH = dcr_pkg::FIFO_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [dcr_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic XFER_VALID,
    input wire logic [dcr_pkg::CHAN_W-1:0] XFER_CHAN,
    output logic XFER_READY,
    output logic EVT_VALID,
    output logic [dcr_pkg::CHAN_W-1:0] EVT_CHAN,
    output logic [31:0] EVT_SRC_ADDR,
    output logic [31:0] EVT_DST_ADDR,
    output logic COUNT_END,
    output logic BLOCK_END,
    output logic [NUM_CHAN-1:0] CHAN_ACTIVE
);
    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [31:0] size_bytes(input logic [1:0] code);
        logic [31:0] b;
        b = dcr_pkg::BYTES_LONG;
        case (code)
            dcr_pkg::SZ_BYTE: b = dcr_pkg::BYTES_BYTE;
            dcr_pkg::SZ_WORD: b = dcr_pkg::BYTES_WORD;
            default: b = dcr_pkg::BYTES_LONG;
        endcase
        return b;
    endfunction
    function automatic logic [31:0] next_addr(input logic [31:0] addr,
                                              input logic [1:0] upd,
                                              input logic [31:0] step,
                                              input logic [31:0] offset);
        logic [31:0] a;
        a = addr;
        case (upd)
            dcr_pkg::UPD_OFFSET: a = addr + offset;
            dcr_pkg::UPD_INC: a = addr + step;
            dcr_pkg::UPD_DEC: a = addr - step;
            default: a = addr;
        endcase
        return a;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return m;
    endfunction
    // Reload value of zero stands for the largest block
    function automatic logic [31:0] block_bytes(input logic [15:0] reload,
                                                input logic [1:0] code);
        logic [16:0] units;
        logic [31:0] b;
        units = (reload == dcr_pkg::BLK_ZERO) ? dcr_pkg::BLK_MAX_UNITS : {1'b0, reload};
        b = 32'(units) * size_bytes(code);
        return b;
    endfunction

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0] source_address [NUM_CHAN];
    logic [31:0] destination_address [NUM_CHAN];
    logic [31:0] address_offset [NUM_CHAN];
    logic [31:0] transfer_count [NUM_CHAN];
    logic [31:0] block_size [NUM_CHAN];
    logic [31:0] address_control [NUM_CHAN];
    logic [NUM_CHAN-1:0] count_end_flag;
    logic [NUM_CHAN-1:0] block_end_flag;
    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic [dcr_pkg::CHAN_W-1:0] apb_chan;
    logic [4:0] apb_win;
    logic apb_mapped;
    logic apb_ro;
    logic apb_setup;
    logic apb_wr;
    logic [31:0] read_word;
    assign apb_chan = PADDR[dcr_pkg::CHAN_MSB:dcr_pkg::CHAN_LSB];
    assign apb_win = PADDR[dcr_pkg::WIN_MSB:dcr_pkg::WIN_LSB];
    assign apb_mapped = !PADDR[dcr_pkg::MAP_BIT] && (apb_win[1:0] == 2'h0);
    assign apb_ro = (apb_win == dcr_pkg::OFS_CHANNEL_STATUS) ||
                    (apb_win == dcr_pkg::OFS_BLOCK_BYTES);
    assign apb_setup = PSEL && !PENABLE;
    // Writes land on the access edge; zero wait states
    assign apb_wr = PSEL && PENABLE && PWRITE && apb_mapped && !apb_ro;
    assign PREADY = 1'b1;
    always_comb begin
        read_word = dcr_pkg::RESET_WORD;
        if (!apb_mapped) begin
            read_word = dcr_pkg::RESET_WORD;
        end else if (apb_win == dcr_pkg::OFS_SOURCE_ADDRESS) begin
            read_word = source_address[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_DESTINATION_ADDRESS) begin
            read_word = destination_address[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_ADDRESS_OFFSET) begin
            read_word = address_offset[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_TRANSFER_COUNT) begin
            read_word = transfer_count[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_BLOCK_SIZE) begin
            read_word = block_size[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_ADDRESS_CONTROL) begin
            read_word = address_control[apb_chan];
        end else if (apb_win == dcr_pkg::OFS_CHANNEL_STATUS) begin
            read_word[dcr_pkg::STS_ACTIVE] = address_control[apb_chan][dcr_pkg::CTL_EN];
            read_word[dcr_pkg::STS_COUNT_END] = count_end_flag[apb_chan];
            read_word[dcr_pkg::STS_BLOCK_END] = block_end_flag[apb_chan];
            read_word[dcr_pkg::STS_FREE_RUN] =
                (transfer_count[apb_chan] == dcr_pkg::COUNT_FREE_RUN);
        end else begin
            read_word = block_bytes(
                block_size[apb_chan][dcr_pkg::BLK_RELOAD_LSB +: dcr_pkg::BLK_FIELD_W],
                address_control[apb_chan][dcr_pkg::CTL_SIZE_LSB +: 2]);
        end
    end
    // Read data and error are registered in the setup cycle
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= dcr_pkg::RESET_WORD;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            PRDATA <= PWRITE ? dcr_pkg::RESET_WORD : read_word;
            PSLVERR <= !apb_mapped || (PWRITE && apb_ro);
        end
    end

    // ****************************************************************
    // Transfer event buffering
    // ****************************************************************
    logic ev_valid;
    logic ev_ready;
    logic [dcr_pkg::CHAN_W-1:0] ev_chan;
    logic take;
    // Drain stalls during a register write, so events never race software
    assign ev_ready = !apb_wr;
    assign take = ev_valid && ev_ready;
    dcr_fifo #(
        .WIDTH(dcr_pkg::CHAN_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .in_valid(XFER_VALID),
        .in_ready(XFER_READY),
        .in_data(XFER_CHAN),
        .out_valid(ev_valid),
        .out_ready(ev_ready),
        .out_data(ev_chan)
    );
    // ****************************************************************
    // Per-transfer decisions for the channel at the FIFO head
    // ****************************************************************
    logic [31:0] hd_ctl;
    logic [31:0] hd_step;
    logic [31:0] hd_cnt;
    logic [15:0] hd_remain;
    logic hd_en;
    logic hd_single;
    logic hd_use_src;
    logic hd_use_dst;
    logic hd_blk_mode;
    logic hd_free_run;
    logic hd_count_done;
    logic hd_reload;
    logic [31:0] next_cnt;
    logic [15:0] next_remain;
    assign hd_ctl = address_control[ev_chan];
    assign hd_en = hd_ctl[dcr_pkg::CTL_EN];
    assign hd_step = size_bytes(hd_ctl[dcr_pkg::CTL_SIZE_LSB +: 2]);
    assign hd_single = hd_ctl[dcr_pkg::CTL_SINGLE];
    assign hd_use_src = !(hd_single && hd_ctl[dcr_pkg::CTL_DIR]);
    assign hd_use_dst = !(hd_single && !hd_ctl[dcr_pkg::CTL_DIR]);
    assign hd_blk_mode = (hd_ctl[dcr_pkg::CTL_MODE_LSB +: 2] == dcr_pkg::MD_REPEAT) ||
                         (hd_ctl[dcr_pkg::CTL_MODE_LSB +: 2] == dcr_pkg::MD_BLOCK);
    assign hd_cnt = transfer_count[ev_chan];
    assign hd_free_run = (hd_cnt == dcr_pkg::COUNT_FREE_RUN);
    // A count below one unit ends the channel as well
    assign hd_count_done = !hd_free_run && (hd_cnt <= hd_step);
    assign hd_remain = block_size[ev_chan][dcr_pkg::BLK_REMAIN_LSB +: dcr_pkg::BLK_FIELD_W];
    assign next_remain = hd_remain - dcr_pkg::BLK_STEP;
    assign hd_reload = hd_blk_mode && (next_remain == dcr_pkg::BLK_ZERO);
    always_comb begin
        next_cnt = hd_cnt;
        if (!hd_free_run) begin
            next_cnt = hd_count_done ? dcr_pkg::COUNT_FREE_RUN : hd_cnt - hd_step;
        end
    end
    // ****************************************************************
    // Register updates
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                source_address[c] <= dcr_pkg::RESET_WORD;
                destination_address[c] <= dcr_pkg::RESET_WORD;
                address_offset[c] <= dcr_pkg::RESET_WORD;
                transfer_count[c] <= dcr_pkg::RESET_WORD;
                block_size[c] <= dcr_pkg::RESET_WORD;
                address_control[c] <= dcr_pkg::RESET_WORD;
            end
        end else if (apb_wr) begin
            if (apb_win == dcr_pkg::OFS_SOURCE_ADDRESS) begin
                source_address[apb_chan] <= merge(source_address[apb_chan], PWDATA, PSTRB);
            end else if (apb_win == dcr_pkg::OFS_DESTINATION_ADDRESS) begin
                destination_address[apb_chan] <=
                    merge(destination_address[apb_chan], PWDATA, PSTRB);
            end else if (apb_win == dcr_pkg::OFS_ADDRESS_OFFSET) begin
                address_offset[apb_chan] <= merge(address_offset[apb_chan], PWDATA, PSTRB);
            end else if (apb_win == dcr_pkg::OFS_TRANSFER_COUNT) begin
                transfer_count[apb_chan] <= merge(transfer_count[apb_chan], PWDATA, PSTRB);
            end else if (apb_win == dcr_pkg::OFS_BLOCK_SIZE) begin
                block_size[apb_chan] <= merge(block_size[apb_chan], PWDATA, PSTRB);
            end else begin
                address_control[apb_chan] <=
                    merge(address_control[apb_chan], PWDATA, PSTRB) & dcr_pkg::CTL_MASK;
            end
        end else if (take && hd_en) begin
            if (hd_use_src) begin
                source_address[ev_chan] <= next_addr(source_address[ev_chan],
                    hd_ctl[dcr_pkg::CTL_SUPD_LSB +: 2], hd_step, address_offset[ev_chan]);
            end
            if (hd_use_dst) begin
                destination_address[ev_chan] <= next_addr(destination_address[ev_chan],
                    hd_ctl[dcr_pkg::CTL_DUPD_LSB +: 2], hd_step,
                    address_offset[ev_chan]);
            end
            transfer_count[ev_chan] <= next_cnt;
            // Upper field is never written here, it only serves as reload
            if (hd_blk_mode) begin
                block_size[ev_chan][dcr_pkg::BLK_REMAIN_LSB +: dcr_pkg::BLK_FIELD_W] <=
                    hd_reload ?
                    block_size[ev_chan][dcr_pkg::BLK_RELOAD_LSB +: dcr_pkg::BLK_FIELD_W] :
                    next_remain;
            end
            if (hd_count_done) begin
                address_control[ev_chan][dcr_pkg::CTL_EN] <= 1'b0;
            end
        end
    end
    // Sticky end flags: set wins over the clear by a control write
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            count_end_flag <= '0;
            block_end_flag <= '0;
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (take && hd_en && (ev_chan == c[dcr_pkg::CHAN_W-1:0]) && hd_count_done) begin
                    count_end_flag[c] <= 1'b1;
                end else if (apb_wr && (apb_win == dcr_pkg::OFS_ADDRESS_CONTROL) &&
                             (apb_chan == c[dcr_pkg::CHAN_W-1:0])) begin
                    count_end_flag[c] <= 1'b0;
                end
                if (take && hd_en && (ev_chan == c[dcr_pkg::CHAN_W-1:0]) && hd_reload) begin
                    block_end_flag[c] <= 1'b1;
                end else if (apb_wr && (apb_win == dcr_pkg::OFS_ADDRESS_CONTROL) &&
                             (apb_chan == c[dcr_pkg::CHAN_W-1:0])) begin
                    block_end_flag[c] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Event report to the engine
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            EVT_VALID <= 1'b0;
            EVT_CHAN <= '0;
            EVT_SRC_ADDR <= dcr_pkg::RESET_WORD;
            EVT_DST_ADDR <= dcr_pkg::RESET_WORD;
            COUNT_END <= 1'b0;
            BLOCK_END <= 1'b0;
        end else begin
            EVT_VALID <= take && hd_en;
            COUNT_END <= take && hd_en && hd_count_done;
            BLOCK_END <= take && hd_en && hd_reload;
            if (take && hd_en) begin
                EVT_CHAN <= ev_chan;
                // An ignored side reports zero
                EVT_SRC_ADDR <= hd_use_src ? source_address[ev_chan] :
                                dcr_pkg::RESET_WORD;
                EVT_DST_ADDR <= hd_use_dst ? destination_address[ev_chan] :
                                dcr_pkg::RESET_WORD;
            end
        end
    end
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            CHAN_ACTIVE[c] = address_control[c][dcr_pkg::CTL_EN];
        end
    end
endmodule
`default_nettype wire

// ### sim/dcr_chk_asserts.sv
/* Port checker for dcr_regs.
   Assumes it is bound to dcr_regs; one clock, reset async low. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module dcr_chk #(
    parameter int NUM_CHAN = 4
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [dcr_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic XFER_VALID,
    input wire logic XFER_READY,
    input wire logic EVT_VALID,
    input wire logic [dcr_pkg::CHAN_W-1:0] EVT_CHAN,
    input wire logic COUNT_END,
    input wire logic BLOCK_END,
    input wire logic [NUM_CHAN-1:0] CHAN_ACTIVE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    a_ready_const: assert property (PSEL |-> PREADY) else $error("ready low");
    a_evt_enabled: assert property (EVT_VALID |-> ($past(CHAN_ACTIVE) >> EVT_CHAN) & 4'h1)
        else $error("event on idle channel");
    a_end_clears: assert property (COUNT_END |-> !CHAN_ACTIVE[EVT_CHAN])
        else $error("enable kept at end");
    a_cnt_end_evt: assert property (COUNT_END |-> EVT_VALID) else $error("end alone");
    a_blk_end_evt: assert property (BLOCK_END |-> EVT_VALID) else $error("reload alone");
    a_rdata_hold: assert property (!$past(PSEL && !PENABLE) |-> $stable(PRDATA)
        && $stable(PSLVERR)) else $error("read data moved");
    a_misalign_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
        else $error("odd address accepted");
    a_ready_full: assert property (!XFER_READY |-> $past(XFER_VALID))
        else $error("full without push");
    c_count_end: cover property (COUNT_END);
    c_block_end: cover property (BLOCK_END);
    c_fifo_full: cover property (!XFER_READY);
endmodule
bind dcr_regs dcr_chk #(.NUM_CHAN(NUM_CHAN)) dcr_chk_inst (.SYS_CLK, .RSTN, .PSEL, .PENABLE,
    .PADDR, .PRDATA, .PREADY, .PSLVERR, .XFER_VALID, .XFER_READY, .EVT_VALID, .EVT_CHAN,
    .COUNT_END, .BLOCK_END, .CHAN_ACTIVE);
`default_nettype wire

// ### sim/dcr_engine_model.sv
/* Transfer engine model: sends a burst of done events for one channel.
   Assumes start is a one-cycle pulse while idle. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Engine model
// ****************************************************************
module dcr_engine_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [1:0] chan_in,
    input wire logic [7:0] num,
    output logic xfer_valid,
    output logic [1:0] xfer_chan,
    input wire logic xfer_ready,
    output logic full_seen
);
    logic [7:0] left;
    logic [1:0] ch;
    assign xfer_valid = left != 8'h00;
    // Idle channel lines show junk, never the last value
    assign xfer_chan = xfer_valid ? ch : ~ch;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 8'h00;
            ch <= 2'h0;
            full_seen <= 1'h0;
        end else begin
            if (start) begin
                left <= num;
                ch <= chan_in;
            end else if (xfer_valid && xfer_ready) begin
                left <= left - 8'h01;
            end
            if (xfer_valid && !xfer_ready) begin
                full_seen <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/dcr_regs_tb.sv
/* Self-checking bench for dcr_regs over APB.
   Assumes the package, design, checker and engine model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench
// ****************************************************************
module dcr_regs_tb;
    localparam logic [4:0] SRC = dcr_pkg::OFS_SOURCE_ADDRESS;
    localparam logic [4:0] DST = dcr_pkg::OFS_DESTINATION_ADDRESS;
    localparam logic [4:0] OFR = dcr_pkg::OFS_ADDRESS_OFFSET;
    localparam logic [4:0] CNT = dcr_pkg::OFS_TRANSFER_COUNT;
    localparam logic [4:0] BLK = dcr_pkg::OFS_BLOCK_SIZE;
    localparam logic [4:0] CTL = dcr_pkg::OFS_ADDRESS_CONTROL;
    logic SYS_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0, e, full_seen;
    logic PREADY, PSLVERR, XFER_VALID, XFER_READY, EVT_VALID, COUNT_END, BLOCK_END;
    logic [7:0] PADDR = 0, num = 0;
    logic [31:0] PWDATA = 0, PRDATA, r;
    logic [1:0] gch = 0, XFER_CHAN, EVT_CHAN;
    logic [3:0] CHAN_ACTIVE;
    int fails = 0, n_checks = 0, cyc = 0, n_evt = 0;
    always #10 SYS_CLK = ~SYS_CLK;
    dcr_regs dcr_regs_inst (.SYS_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PSTRB(4'hF), .PRDATA, .PREADY, .PSLVERR, .XFER_VALID, .XFER_CHAN, .XFER_READY,
        .EVT_VALID, .EVT_CHAN, .EVT_SRC_ADDR(), .EVT_DST_ADDR(), .COUNT_END, .BLOCK_END,
        .CHAN_ACTIVE);
    dcr_engine_model dcr_engine_model_inst (.clk(SYS_CLK), .rst_n(RSTN), .start(go),
        .chan_in(gch), .num, .xfer_valid(XFER_VALID), .xfer_chan(XFER_CHAN),
        .xfer_ready(XFER_READY), .full_seen);
    task conclude;
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (EVT_VALID === 1'h1) n_evt <= n_evt + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'h1) @(posedge SYS_CLK);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(r, x);
    endtask
    function automatic logic [7:0] ad(input logic [1:0] c, input logic [4:0] o);
        return {1'h0, c, o};
    endfunction
    // Burst of n events; w register writes meanwhile stall the drain
    task fire(input logic [1:0] c, input logic [7:0] n, input int w);
        int base;
        base = n_evt;
        go <= 1'h1;
        gch <= c;
        num <= n;
        @(posedge SYS_CLK);
        go <= 1'h0;
        for (int i = 0; i < w; i++) wr(ad(3, OFR), i);
        while (n_evt != base + n) @(posedge SYS_CLK);
    endtask
    initial begin
        repeat (2) @(posedge SYS_CLK);
        RSTN <= 1'h1;
        @(posedge SYS_CLK);
        rd(ad(0, DST), 32'h0);
        rd(ad(0, OFR), 32'h0);
        rd(ad(0, CNT), 32'h0);
        wr(ad(0, DST), 32'hA5C30F1E);
        rd(ad(0, DST), 32'hA5C30F1E);
        wr(ad(2, OFR), 32'h10);
        rd(ad(2, OFR), 32'h10);
        apb(1'h0, 8'h82, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int s = 0; s < 3; s++) begin
            wr(ad(1, DST), 32'h100);
            wr(ad(1, CNT), 32'hFFFFFFFF);
            wr(ad(1, CTL), 32'h401 | (s << 1));
            fire(1, 1, 0);
            rd(ad(1, CNT), 32'hFFFFFFFF - (1 << s));
            rd(ad(1, DST), 32'h100 + (1 << s));
        end
        wr(ad(1, CNT), 32'h6);
        wr(ad(1, CTL), 32'h405);
        fire(1, 2, 0);
        rd(ad(1, CNT), 32'h0);
        rd(ad(1, dcr_pkg::OFS_CHANNEL_STATUS), 32'hA);
        wr(ad(2, SRC), 32'h200);
        wr(ad(2, DST), 32'h300);
        wr(ad(2, CTL), 32'h4A1);
        fire(2, 1, 0);
        rd(ad(2, DST), 32'h300);
        rd(ad(2, SRC), 32'h210);
        wr(ad(2, CTL), 32'h661);
        fire(2, 1, 0);
        rd(ad(2, SRC), 32'h210);
        rd(ad(2, DST), 32'h2FF);
        rd(ad(2, CNT), 32'h0);
        wr(ad(3, BLK), 32'h00020002);
        wr(ad(3, CTL), 32'h9);
        fire(3, 1, 0);
        rd(ad(3, BLK), 32'h00020001);
        wr(ad(3, CTL), 32'h11);
        fire(3, 1, 0);
        rd(ad(3, BLK), 32'h00020002);
        wr(ad(3, CTL), 32'h1);
        fire(3, 1, 0);
        rd(ad(3, BLK), 32'h00020002);
        wr(ad(3, BLK), 32'h0);
        for (int s = 0; s < 3; s++) begin
            wr(ad(3, CTL), s << 1);
            rd(ad(3, dcr_pkg::OFS_BLOCK_BYTES), 32'h10000 << s);
        end
        wr(ad(0, CTL), 32'h1);
        fire(0, 100, 40);
        chk({31'h0, full_seen}, 32'h1);
        rd(ad(0, CNT), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
